/* verilog/rmcl_ctrl.sv */
// RS-232 modem control line handler: DTR/RTS drive, DSR/CTS/DCD supervision
module rmcl_ctrl
    import rmcl_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // Configuration
    input wire logic [1:0] i_mode,
    input wire logic [7:0] i_send_delay,
    input wire logic [7:0] i_off_delay,
    // Commands from the link layer
    input wire logic i_handshake_line_command,
    input wire logic i_tx_start,
    input wire logic i_tx_done,
    // Modem status pins, asserted high
    input wire logic i_dsr,
    input wire logic i_cts,
    input wire logic i_dcd,
    // Modem control pins, asserted high
    output logic o_dtr,
    output logic o_rts,
    // Status to the link layer
    output logic o_rx_enable,
    output logic o_tx_enable,
    output logic o_tx_grant,
    output logic o_tx_abort,
    output logic o_modem_lost
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] mode_q;
        logic dsr_q;
        logic [PRE_W-1:0] pre;
        rmcl_line_t line;
        logic [MS_W-1:0] line_ms;
        logic [MS_W-1:0] dcd_ms;
        rmcl_seq_t seq;
        logic [MS_W-1:0] rts_ms;
        logic hang;
        logic [MS_W-1:0] hang_ms;
        logic dtr, rts, rx_en, tx_en;
        logic lost, grant, abort;
    } rmcl_state_t;

    rmcl_state_t s;
    rmcl_state_t next_s;

    logic [2:0] pins_sync;
    logic dsr, cts, dcd;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Millisecond counter step, saturating so long waits never wrap
    function automatic logic [MS_W-1:0] ms_step(input logic [MS_W-1:0] cnt, input logic tick);
        return (tick && (cnt != '1)) ? cnt + MS_W'(1) : cnt;
    endfunction

    // Delay setting in 20 ms units turned into milliseconds
    function automatic logic [MS_W-1:0] steps_ms(input logic [7:0] steps);
        return MS_W'({6'h00, steps} * MS_W'(STEP_MS));
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    rmcl_sync #(.W(3)) u_sync (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_async({i_dcd, i_cts, i_dsr}),
        .o_sync(pins_sync)
    );

    assign dsr = pins_sync[0];
    assign cts = pins_sync[1];
    assign dcd = pins_sync[2];

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    logic tick, mode_chg, dsr_fell, lost_set;
    logic is_fd, is_hdc, is_hdn, is_hd, modem, dcd_sup;
    logic line_up, sending;

    always_comb begin
        next_s = s;
        next_s.abort = 1'b0;
        lost_set = 1'b0;
        // Millisecond tick prescaler
        tick = (s.pre == PRE_W'(TICK_CYCLES_P - 1));
        next_s.pre = tick ? '0 : s.pre + PRE_W'(1);
        // Mode decode and mode change detect
        mode_chg = (i_mode != s.mode_q);
        next_s.mode_q = i_mode;
        next_s.dsr_q = dsr;
        dsr_fell = s.dsr_q & ~dsr;
        is_fd = (s.mode_q == MODE_FULL);
        is_hdc = (s.mode_q == MODE_HD_CARRIER);
        is_hdn = (s.mode_q == MODE_HD_NO_CARRIER);
        is_hd = is_hdc | is_hdn;
        modem = (s.mode_q != MODE_NONE);
        dcd_sup = is_fd | is_hdc;
        if (i_handshake_line_command) begin
            next_s.hang = 1'b1;
            next_s.hang_ms = '0;
        end else if (s.hang) begin
            next_s.hang_ms = ms_step(s.hang_ms, tick);
            if (s.hang_ms >= MS_W'(HANGUP_MS)) begin
                next_s.hang = 1'b0;
            end
        end
        if (mode_chg || !dcd_sup) begin
            next_s.line = LN_UP;
            next_s.line_ms = '0;
            next_s.dcd_ms = '0;
        end else begin
            case (s.line)
                LN_UP: begin
                    if (dsr_fell) begin
                        next_s.line = LN_DSR_DROP;
                        next_s.line_ms = '0;
                        next_s.dcd_ms = '0;
                    end else if (dsr && !dcd) begin
                        next_s.dcd_ms = ms_step(s.dcd_ms, tick);
                        if (s.dcd_ms >= MS_W'(DCD_LOSS_MS)) begin
                            next_s.line = LN_DCD_DROP;
                            next_s.line_ms = '0;
                            next_s.dcd_ms = '0;
                            lost_set = 1'b1;
                        end
                    end else begin
                        next_s.dcd_ms = '0;
                    end
                end
                LN_DSR_DROP: begin
                    next_s.line_ms = ms_step(s.line_ms, tick);
                    if (s.line_ms >= MS_W'(DSR_DROP_MS)) begin
                        next_s.line = LN_UP;
                        next_s.line_ms = '0;
                    end
                end
                LN_DCD_DROP: begin
                    if (!dsr) begin
                        next_s.line = LN_DSR_DROP;
                        next_s.line_ms = '0;
                    end else begin
                        next_s.line_ms = ms_step(s.line_ms, tick);
                        if (s.line_ms >= MS_W'(DTR_REUP_MS)) begin
                            next_s.line = LN_UP;
                            next_s.line_ms = '0;
                        end
                    end
                end
                default: next_s.line = LN_UP;
            endcase
        end

        // RTS keying sequence for the half-duplex modes
        if (mode_chg || !is_hd) begin
            next_s.seq = SQ_IDLE;
            next_s.rts_ms = '0;
        end else if (!dsr && (s.seq != SQ_IDLE)) begin
            // DSR loss drops RTS and kills a pending send
            next_s.seq = SQ_IDLE;
            next_s.abort = (s.seq != SQ_OFF_DLY);
        end else begin
            case (s.seq)
                SQ_IDLE: begin
                    if (i_tx_start && dsr) begin
                        next_s.rts_ms = '0;
                        next_s.seq = (i_send_delay == 8'h00) ? SQ_WAIT_CTS : SQ_SEND_DLY;
                    end
                end
                SQ_SEND_DLY: begin
                    next_s.rts_ms = ms_step(s.rts_ms, tick);
                    if (s.rts_ms >= steps_ms(i_send_delay)) begin
                        next_s.seq = SQ_WAIT_CTS;
                    end
                end
                SQ_WAIT_CTS: begin
                    next_s.rts_ms = ms_step(s.rts_ms, tick);
                    if (cts) begin
                        next_s.seq = SQ_SENDING;
                    end else if (s.rts_ms >= MS_W'(CTS_WAIT_MS)) begin
                        next_s.seq = SQ_IDLE;
                        next_s.abort = 1'b1;
                    end
                end
                SQ_SENDING: begin
                    if (i_tx_done) begin
                        next_s.rts_ms = '0;
                        next_s.seq = (i_off_delay == 8'h00) ? SQ_IDLE : SQ_OFF_DLY;
                    end
                end
                SQ_OFF_DLY: begin
                    next_s.rts_ms = ms_step(s.rts_ms, tick);
                    if (s.rts_ms >= steps_ms(i_off_delay)) begin
                        next_s.seq = SQ_IDLE;
                    end
                end
                default: next_s.seq = SQ_IDLE;
            endcase
        end

        if (modem && !mode_chg) begin
            if (!dsr || lost_set) begin
                next_s.lost = 1'b1;
            end else if ((dcd_sup && dcd) || is_hdn) begin
                next_s.lost = 1'b0;
            end
        end

        // Pin and enable outputs, registered from the next state
        line_up = (next_s.line == LN_UP);
        sending = (next_s.seq == SQ_SENDING);
        case (s.mode_q)
            MODE_FULL: begin
                next_s.dtr = line_up;
                next_s.rts = line_up;
                next_s.rx_en = dsr & dcd;
                next_s.tx_en = cts & dcd & dsr & line_up;
            end
            MODE_HD_CARRIER: begin
                next_s.dtr = line_up;
                next_s.rts = (next_s.seq != SQ_IDLE);
                next_s.rx_en = dsr & dcd;
                next_s.tx_en = cts & dcd & dsr & sending;
            end
            MODE_HD_NO_CARRIER: begin
                next_s.dtr = 1'b1;
                next_s.rts = (next_s.seq != SQ_IDLE);
                next_s.rx_en = dsr & dcd;
                next_s.tx_en = cts & dsr & sending;
            end
            default: begin
                next_s.dtr = 1'b1;
                next_s.rts = 1'b0;
                next_s.rx_en = 1'b1;
                next_s.tx_en = 1'b1;
            end
        endcase
        if (next_s.hang) begin
            next_s.dtr = 1'b0;
        end
        next_s.grant = sending;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from flip-flops
    assign o_dtr = s.dtr;
    assign o_rts = s.rts;
    assign o_rx_enable = s.rx_en;
    assign o_tx_enable = s.tx_en;
    assign o_tx_grant = s.grant;
    assign o_tx_abort = s.abort;
    assign o_modem_lost = s.lost;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    chk_none_pins: assert property (s.mode_q == MODE_NONE && !mode_chg && !next_s.hang |=>
        o_dtr && !o_rts && o_rx_enable && o_tx_enable) else $error("no-handshake pin levels wrong");
    chk_dsr_drop: assert property (is_fd && !mode_chg && dsr_fell |=> !o_dtr && !o_rts [*2])
        else $error("DSR loss did not drop DTR and RTS");
    chk_lost_set: assert property (modem && !mode_chg && !dsr |=> o_modem_lost)
        else $error("modem-lost not set on DSR low");
    chk_dsr_block: assert property (modem && !mode_chg && !dsr |=> !o_rx_enable && !o_tx_enable)
        else $error("traffic enabled while DSR low");
    chk_dcd_rx: assert property (dcd_sup && !mode_chg && dsr && !dcd |=> !o_rx_enable)
        else $error("reception allowed while DCD low");
    chk_fd_tx: assert property (o_tx_enable && $past(is_fd) && !$past(mode_chg) |->
        $past(cts) && $past(dcd) && $past(dsr)) else $error("full-duplex transmit without all inputs");
    chk_hdn_clear: assert property (is_hdn && !mode_chg && dsr |=> !o_modem_lost)
        else $error("modem-lost not cleared with DSR high");
    chk_cts_abort: assert property (s.seq == SQ_WAIT_CTS && !cts && dsr && !mode_chg && is_hd
        && s.rts_ms >= MS_W'(CTS_WAIT_MS) |=> o_tx_abort && !o_rts) else $error("CTS timeout not handled");
    // Grant rises one edge after the sequencer sees synchronised CTS
    chk_grant_cts: assert property ($rose(o_tx_grant) |-> $past(cts))
        else $error("transmit granted without CTS");
endmodule

/* shared/rmcl_pkg.sv */
// Constants, encodings and timing for the RS-232 modem control line handler
package rmcl_pkg;

    // ------------------------------------------------------------
    // Clock and timer base
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int PRE_W = 18;
    localparam int MS_W = 14;

    // ------------------------------------------------------------
    // Supervision intervals in milliseconds
    // ------------------------------------------------------------
    // DTR and RTS low after DSR loss in full duplex, DTR only in half duplex with carrier, inside the 1 to 2 s window
    localparam int DSR_DROP_MS = 1500;
    // DCD loss before DTR drops, inside the 9 to 10 s window
    localparam int DCD_LOSS_MS = 9500;
    // DTR low after a DCD timeout, inside the 5 to 6 s window
    localparam int DTR_REUP_MS = 5500;
    // Longest wait for CTS after RTS rises
    localparam int CTS_WAIT_MS = 1000;
    // Send and off delays count in steps of this size
    localparam int STEP_MS = 20;
    // DTR low time on a hang-up command
    localparam int HANGUP_MS = 1500;

    // ------------------------------------------------------------
    // Line mode selection
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_NONE = 2'h0;
    localparam logic [1:0] MODE_FULL = 2'h1;
    localparam logic [1:0] MODE_HD_CARRIER = 2'h2;
    localparam logic [1:0] MODE_HD_NO_CARRIER = 2'h3;

    // ------------------------------------------------------------
    // State encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LN_UP = 2'b00,
        LN_DSR_DROP = 2'b01,
        LN_DCD_DROP = 2'b10
    } rmcl_line_t;

    typedef enum logic [2:0] {
        SQ_IDLE = 3'b000,
        SQ_SEND_DLY = 3'b001,
        SQ_WAIT_CTS = 3'b010,
        SQ_SENDING = 3'b011,
        SQ_OFF_DLY = 3'b100
    } rmcl_seq_t;

endpackage

/* verilog/rmcl_sync.sv */
// Two-flop synchroniser for the modem status pins
module rmcl_sync #(
    parameter int W = 3
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // Pins and synchronised levels
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } rmcl_sync_t;

    rmcl_sync_t s;
    rmcl_sync_t next_s;

    // Meta stage is read only by the stable stage
    always_comb begin
        next_s = s;
        next_s.meta = i_async;
        next_s.stable = s.meta;
    end

    // State register
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign o_sync = s.stable;

endmodule

/* test/rmcl_modem_model.sv */
// Behavioural modem on the far side of the modem control line handler
module rmcl_modem_model (
    // Clock
    input wire logic i_clk,
    // Control pin from the handler and scenario commands
    input wire logic i_rts,
    input wire logic i_dsr_on,
    input wire logic i_dcd_on,
    input wire logic [15:0] i_cts_lag,
    // Status pins towards the handler
    output logic o_dsr,
    output logic o_cts,
    output logic o_dcd
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] lag_cnt;

    // Cycles since RTS rose, cleared while RTS is low
    always_ff @(posedge i_clk) begin
        if (!i_rts) begin
            lag_cnt <= 16'h0000;
        end else if (lag_cnt != 16'hffff) begin
            lag_cnt <= lag_cnt + 16'h0001;
        end
    end

    // CTS answers RTS after the key-up lag; a lag of all ones never answers
    assign o_cts = i_rts && (i_cts_lag != 16'hffff) && (lag_cnt >= i_cts_lag);
    // DSR and DCD follow the scenario's commands
    assign o_dsr = i_dsr_on;
    assign o_dcd = i_dcd_on;
endmodule

/* test/tb_top.sv */
// Self-checking bench for the modem control line handler
module tb_top
    import rmcl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // Short tick keeps second-scale intervals affordable
    localparam int T = 2;
    localparam int LIM = 25000;

    logic clk = 1'h0;
    logic srst, hang, tx_start, tx_done, dsr_on, dcd_on;
    logic [1:0] mode;
    logic [7:0] sdly, odly;
    logic [15:0] cts_lag;
    logic dsr, cts, dcd, dtr, rts, rx_en, tx_en, grant, abort, lost;
    int n_errors = 0;
    int checks = 0;
    int n;

    // Clock at 250 MHz
    always #2 clk = ~clk;

    rmcl_ctrl #(.TICK_CYCLES_P(T)) rmcl_ctrl_i (
        .i_clk(clk), .i_srst(srst), .i_mode(mode), .i_send_delay(sdly), .i_off_delay(odly),
        .i_handshake_line_command(hang), .i_tx_start(tx_start), .i_tx_done(tx_done),
        .i_dsr(dsr), .i_cts(cts), .i_dcd(dcd), .o_dtr(dtr), .o_rts(rts), .o_rx_enable(rx_en),
        .o_tx_enable(tx_en), .o_tx_grant(grant), .o_tx_abort(abort), .o_modem_lost(lost)
    );

    rmcl_modem_model rmcl_modem_model_i (
        .i_clk(clk), .i_rts(rts), .i_dsr_on(dsr_on), .i_dcd_on(dcd_on), .i_cts_lag(cts_lag),
        .o_dsr(dsr), .o_cts(cts), .o_dcd(dcd)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask

    // Output selected by index, for the bounded waits
    function automatic logic pick(input int sel);
        case (sel)
            0: return dtr;
            1: return rts;
            2: return grant;
            default: return abort;
        endcase
    endfunction

    // Falling-edge cycles until the output reaches a level, capped
    task automatic wait_sig(input int sel, input logic val, input int lim, output int k);
        k = 0;
        while (pick(sel) !== val && k <= lim) begin
            @(negedge clk);
            k++;
        end
    endtask

    task automatic chk(input logic got, input logic exp, input string what);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask

    task automatic chk_rng(input int k, input int lo, input int hi, input string what);
        checks++;
        if (k < lo || k > hi) begin
            n_errors++;
            $display("[FAIL] %0t %s took %0d cycles", $time, what, k);
        end
    endtask

    // One-cycle command pulses: 0 hang-up, 1 start, 2 done
    task automatic pulse(input int which);
        if (which == 0) hang = 1'h1;
        if (which == 1) tx_start = 1'h1;
        if (which == 2) tx_done = 1'h1;
        cyc(1);
        hang = 1'h0;
        tx_start = 1'h0;
        tx_done = 1'h0;
    endtask

    task automatic tally_and_finish;
        $display("errors %0d, checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    initial begin
        #320000;
        n_errors++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        srst = 1'h1;
        mode = 2'h0;
        sdly = 8'h00;
        odly = 8'h00;
        hang = 1'h0;
        tx_start = 1'h0;
        tx_done = 1'h0;
        dsr_on = 1'h0;
        dcd_on = 1'h0;
        cts_lag = 16'hffff;
        cyc(20);
        srst = 1'h0;
        cyc(6);
        // No handshaking with every pin low
        chk(dtr, 1'h1, "mode 0 dtr");
        chk(rts, 1'h0, "mode 0 rts");
        chk(rx_en, 1'h1, "mode 0 rx");
        chk(tx_en, 1'h1, "mode 0 tx");
        // Hang-up lowers DTR for a while
        pulse(0);
        wait_sig(0, 1'h0, 4, n);
        chk_rng(n, 0, 2, "hang-up drop");
        wait_sig(0, 1'h1, LIM, n);
        chk_rng(n, 1499 * T, 1502 * T + 4, "hang-up length");
        // Full duplex, modem ready
        mode = 2'h1;
        dsr_on = 1'h1;
        dcd_on = 1'h1;
        cts_lag = 16'h0000;
        cyc(8);
        chk(dtr, 1'h1, "full dtr");
        chk(rts, 1'h1, "full rts");
        chk(tx_en, 1'h1, "full tx");
        cts_lag = 16'hffff;
        cyc(5);
        chk(tx_en, 1'h0, "tx without cts");
        chk(rx_en, 1'h1, "rx without cts");
        cts_lag = 16'h0000;
        // DSR loss drops both lines for a while
        dsr_on = 1'h0;
        wait_sig(0, 1'h0, 6, n);
        chk_rng(n, 2, 4, "dsr loss dtr");
        chk(rts, 1'h0, "dsr loss rts");
        chk(lost, 1'h1, "dsr loss lost");
        chk(rx_en, 1'h0, "dsr loss rx");
        chk(tx_en, 1'h0, "dsr loss tx");
        wait_sig(0, 1'h1, LIM, n);
        chk_rng(n, 1499 * T, 1502 * T + 4, "dsr drop length");
        chk(rts, 1'h1, "rts back");
        chk(rx_en, 1'h0, "rx while dsr low");
        dsr_on = 1'h1;
        cyc(5);
        chk(lost, 1'h0, "lost clear full");
        // DCD loss; a mode change restarts the timer
        dcd_on = 1'h0;
        cyc(5);
        chk(rx_en, 1'h0, "dcd loss rx");
        chk(tx_en, 1'h0, "dcd loss tx");
        chk(dtr, 1'h1, "dcd loss dtr held");
        cyc(4000 * T);
        mode = 2'h2;
        wait_sig(0, 1'h0, LIM, n);
        chk_rng(n, 9499 * T, 9502 * T + 6, "dcd timeout");
        chk(lost, 1'h1, "dcd timeout lost");
        wait_sig(0, 1'h1, LIM, n);
        chk_rng(n, 5499 * T, 5502 * T + 4, "dtr reraise");
        dcd_on = 1'h1;
        cyc(5);
        chk(lost, 1'h0, "lost clear carrier");
        chk(rts, 1'h0, "rts idle half duplex");
        // Keying with send delay 40 ms and off delay 20 ms
        sdly = 8'h02;
        odly = 8'h01;
        cts_lag = 16'h0003;
        pulse(1);
        wait_sig(2, 1'h1, LIM, n);
        chk_rng(n, 39 * T, 42 * T + 6, "send delay");
        chk(rts, 1'h1, "rts while sending");
        chk(tx_en, 1'h1, "tx while granted");
        cyc(10);
        pulse(2);
        wait_sig(2, 1'h0, 4, n);
        chk_rng(n, 0, 2, "grant release");
        wait_sig(1, 1'h0, LIM, n);
        chk_rng(n, 19 * T, 22 * T + 4, "off delay");
        // No CTS: abort after one second
        sdly = 8'h00;
        odly = 8'h00;
        cts_lag = 16'hffff;
        cyc(2);
        pulse(1);
        wait_sig(3, 1'h1, LIM, n);
        chk_rng(n, 999 * T, 1002 * T + 4, "cts timeout");
        chk(rts, 1'h0, "rts after abort");
        chk(grant, 1'h0, "no grant after abort");
        // Zero send delay starts as soon as CTS comes
        cts_lag = 16'h0000;
        cyc(2);
        pulse(1);
        wait_sig(2, 1'h1, 10, n);
        chk_rng(n, 1, 8, "zero send delay");
        pulse(2);
        wait_sig(1, 1'h0, 4, n);
        chk_rng(n, 0, 2, "zero off delay");
        // No-carrier mode: DCD not supervised, not needed to send
        mode = 2'h3;
        dcd_on = 1'h0;
        cyc(6);
        chk(rx_en, 1'h0, "no-carrier rx");
        chk(lost, 1'h0, "no-carrier lost");
        pulse(1);
        wait_sig(2, 1'h1, 10, n);
        chk_rng(n, 1, 8, "no-carrier grant");
        chk(tx_en, 1'h1, "no-carrier tx");
        pulse(2);
        cyc(9700 * T);
        chk(dtr, 1'h1, "no dcd timeout");
        dsr_on = 1'h0;
        cyc(5);
        chk(lost, 1'h1, "no-carrier dsr loss");
        dsr_on = 1'h1;
        cyc(5);
        chk(lost, 1'h0, "no-carrier clear");
        tally_and_finish();
    end
endmodule
